//--- pixel_out_map.svh
// Bit positions, offsets and timing figures of the dual-edge pixel output
`ifndef PIXEL_OUT_MAP_SVH
`define PIXEL_OUT_MAP_SVH

`define PO_BUS_W        36
`define PO_COMP_W       12
`define PO_OFS_18       6'd0
`define PO_OFS_15       6'd3
`define PO_OFS_12       6'd6
`define PO_BITS_18      6'd12
`define PO_BITS_15      6'd10
`define PO_BITS_12      6'd8
`define PO_FULL_B_LSB   0
`define PO_FULL_G_LSB   12
`define PO_FULL_R_LSB   24
`define PO_MAX_PCLK_KHZ 148500
`define PO_MCLK_KHZ     10000
`define PO_FIFO_DEPTH   8
`define PO_RST_BUS      36'h0_0000_0000
`define PO_RST_FMT      2'h0
`define PO_RST_WIDTH    2'h0

`endif

//--- pixel_out_pkg.sv
// Types shared by the dual-edge pixel output and its testbench
package pixel_out_pkg;

  // One 4:4:4 pixel with its separate syncs
  typedef struct packed {
    logic [11:0] cr_r;
    logic [11:0] y_g;
    logic [11:0] cb_b;
    logic        hs;
    logic        vs;
    logic        de;
  } pixel_t;

  typedef enum logic [1:0] {
    FMT_FULL     = 2'b00,
    FMT_HALF     = 2'b01,
    FMT_HALF_CLK = 2'b10
  } out_fmt_t;

  typedef enum logic [1:0] {
    BW_18 = 2'b00,
    BW_15 = 2'b01,
    BW_12 = 2'b10
  } bus_width_t;

endpackage : pixel_out_pkg

//--- pixel_fifo.sv
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
`include "pixel_out_map.svh"

module pixel_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = `PO_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pixel_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign count_next = count_reg + (AW + 1)'(push) - (AW + 1)'(pop);

  // Storage, written only on an accepted word
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop) rd_reg <= rd_reg + 1'b1;
      count_reg <= count_next;
    end
  end

  // Ready is registered so the source sees a clean flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= (count_next < (AW + 1)'(DEPTH));
    end
  end

  property p_no_overfill;
    // Ready leaves reset low for one edge, so skip the first edge after release
    @(posedge clk) disable iff (!rst_n)
      $past(rst_n) && !in_ready |-> count_reg == (AW + 1)'(DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("fifo refused while not full");

  cover_full: cover property (@(posedge clk) disable iff (!rst_n) !in_ready && in_valid);

endmodule : pixel_fifo

//--- dual_edge_pixel_output.sv
// Dual-edge and half-rate-clock 4:4:4 pixel output formatter
`timescale 1ns/100ps
`include "pixel_out_map.svh"

// Operation
// [R1] Half-width mode: output clock at pixel rate, data changes twice per pixel.
// [R2] First pixel half goes with rising clock edge, second half with falling.
// [R3] 18-bit: blue and low green first, high green and red second, lines 0-17.
// [R4] 15-bit: same pattern on lines 3-17, lines 0-2 unused.
// [R5] 12-bit: same pattern on lines 6-17, lines 0-5 unused.
// [R6] YCbCr uses RGB positions: Cb for blue, Y for green, Cr for red.
// [R7] Horizontal sync, vertical sync and data enable have their own pins.
// [R8] Half-rate-clock variant keeps the ordinary full-width bus layout.
// [R9] Half-rate-clock variant: clock at half pixel rate, data on both edges.
// [R10] Output bus up to 36 bits, clock up to 148.5 MHz.
// [R11] Format and bus width come from static configuration inputs.
module dual_edge_pixel_output
  import pixel_out_pkg::*;
#(
  parameter int BUS_W = `PO_BUS_W,
  parameter int DEPTH = `PO_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             MCLK,
  input  wire logic             RESET_N,
  // Static configuration pins
  input  wire logic [1:0]       OUT_FORMAT,
  input  wire logic [1:0]       BUS_WIDTH,
  // Incoming pixels
  input  wire logic             PIX_VALID,
  output logic                  PIX_READY,
  input  wire pixel_t           PIX_DATA,
  // Video output pins
  output logic [BUS_W-1:0]      VIDEO_OUT_BUS,
  output logic                  PIXEL_CLK_OUT,
  output logic                  HSYNC_OUT,
  output logic                  VSYNC_OUT,
  output logic                  DE_OUT
);

  // Bus layout fixed at 36 lines; the MCLK figure is checked against the 148.5 MHz pin limit
  if (BUS_W != `PO_BUS_W || `PO_MCLK_KHZ > `PO_MAX_PCLK_KHZ) begin : g_bad_bus // R10
    $error("dual_edge_pixel_output: bus must be 36 lines");
  end

  // Half-width word for one edge; narrow widths keep the component MSBs
  function automatic logic [35:0] half_word(pixel_t p, bus_width_t w, logic second);
    logic [5:0]  n;
    logic [5:0]  h;
    logic [5:0]  o;
    logic [35:0] b;
    logic [35:0] g;
    logic [35:0] r;
    logic [35:0] v;
    case (w)
      BW_15: begin
        n = `PO_BITS_15;
        o = `PO_OFS_15;
      end
      BW_12: begin
        n = `PO_BITS_12;
        o = `PO_OFS_12;
      end
      default: begin
        n = `PO_BITS_18;
        o = `PO_OFS_18;
      end
    endcase
    h = n >> 1;
    b = {24'h00_0000, p.cb_b} >> (`PO_BITS_18 - n); // R6
    g = {24'h00_0000, p.y_g} >> (`PO_BITS_18 - n);
    r = {24'h00_0000, p.cr_r} >> (`PO_BITS_18 - n);
    if (second) begin
      v = (g >> h) | (r << h);
    end else begin
      v = b | ((g & ((36'h0_0000_0001 << h) - 36'h0_0000_0001)) << n);
    end
    return v << o;
  endfunction : half_word

  // Ordinary full-width layout with separate syncs
  function automatic logic [35:0] full_word(pixel_t p);
    logic [35:0] v;
    v = `PO_RST_BUS;
    v[`PO_FULL_B_LSB +: `PO_COMP_W] = p.cb_b;
    v[`PO_FULL_G_LSB +: `PO_COMP_W] = p.y_g;
    v[`PO_FULL_R_LSB +: `PO_COMP_W] = p.cr_r;
    return v;
  endfunction : full_word

  logic [1:0]  fmt_s1_reg;
  logic [1:0]  fmt_s2_reg;
  logic [1:0]  wid_s1_reg;
  logic [1:0]  wid_s2_reg;
  out_fmt_t    fmt;
  bus_width_t  wid;
  logic        phase_reg;
  logic        load;
  logic        head_valid;
  pixel_t      head;
  pixel_t      cur_reg;
  pixel_t      cur_next;

  // Config pins are asynchronous straps; two flops before use
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fmt_s1_reg <= `PO_RST_FMT;
      fmt_s2_reg <= `PO_RST_FMT;
      wid_s1_reg <= `PO_RST_WIDTH;
      wid_s2_reg <= `PO_RST_WIDTH;
    end else begin
      fmt_s1_reg <= OUT_FORMAT;
      fmt_s2_reg <= fmt_s1_reg;
      wid_s1_reg <= BUS_WIDTH;
      wid_s2_reg <= wid_s1_reg;
    end
  end

  // Static while video runs, so no retiming against the pixel phase
  assign fmt = out_fmt_t'(fmt_s2_reg); // R11
  assign wid = bus_width_t'(wid_s2_reg); // R11

  // Pixel buffer; stalls the source through PIX_READY
  pixel_fifo #(
    .WIDTH ($bits(pixel_t)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (RESET_N),
    .in_valid  (PIX_VALID),
    .in_ready  (PIX_READY),
    .in_data   (PIX_DATA),
    .out_valid (head_valid),
    .out_ready (load),
    .out_data  (head)
  );

  // Pixel-rate enable: a new pixel every second MCLK
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
    end
  end

  assign load     = ~phase_reg;
  // Underrun sends a blank pixel rather than stalling the clock
  assign cur_next = head_valid ? head : pixel_t'('0);

  // Current pixel held for the second half
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cur_reg <= pixel_t'('0);
    end else if (load) begin
      cur_reg <= cur_next;
    end
  end

  // Syncs and enable ride on their own pins, one value per pixel
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HSYNC_OUT <= 1'b0;
      VSYNC_OUT <= 1'b0;
      DE_OUT    <= 1'b0;
    end else if (load) begin
      HSYNC_OUT <= cur_next.hs; // R7
      VSYNC_OUT <= cur_next.vs; // R7
      DE_OUT    <= cur_next.de; // R7
    end
  end

  // Data pins: two halves per pixel, or one full word
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      VIDEO_OUT_BUS <= `PO_RST_BUS;
    end else if (fmt == FMT_HALF) begin
      VIDEO_OUT_BUS <= half_word(load ? cur_next : cur_reg, wid, ~load); // R2 R3 R4 R5
    end else if (load) begin
      VIDEO_OUT_BUS <= full_word(cur_next); // R8
    end
  end

  // Clock pin: high for the first half, or toggled per pixel at half rate
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PIXEL_CLK_OUT <= 1'b0;
    end else if (fmt == FMT_HALF_CLK) begin
      if (load) PIXEL_CLK_OUT <= ~PIXEL_CLK_OUT; // R9
    end else begin
      PIXEL_CLK_OUT <= load; // R1
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  property p_pix_clk;
    fmt == FMT_HALF && load |=> PIXEL_CLK_OUT ##1 !PIXEL_CLK_OUT;
  endproperty
  a_pix_clk: assert property (p_pix_clk) else $error("clock not at pixel rate"); // R1

  property p_second_half;
    fmt == FMT_HALF && !load |=> VIDEO_OUT_BUS == half_word(cur_reg, wid, 1'b1);
  endproperty
  a_second_half: assert property (p_second_half) else $error("second half wrong"); // R2

  property p_map18;
    fmt == FMT_HALF && wid == BW_18 && load |=>
      VIDEO_OUT_BUS == {18'h0_0000, cur_reg.y_g[5:0], cur_reg.cb_b};
  endproperty
  a_map18: assert property (p_map18) else $error("18-bit first edge wrong"); // R3

  property p_map15;
    fmt == FMT_HALF && wid == BW_15 && !load |=>
      VIDEO_OUT_BUS[2:0] == 3'h0 && VIDEO_OUT_BUS[17:8] == cur_reg.cr_r[11:2];
  endproperty
  a_map15: assert property (p_map15) else $error("15-bit second edge wrong"); // R4

  property p_map12;
    fmt == FMT_HALF && wid == BW_12 && load |=>
      VIDEO_OUT_BUS[5:0] == 6'h00 && VIDEO_OUT_BUS[13:6] == cur_reg.cb_b[11:4];
  endproperty
  a_map12: assert property (p_map12) else $error("12-bit first edge wrong"); // R5

  property p_syncs;
    !load |-> HSYNC_OUT == cur_reg.hs && VSYNC_OUT == cur_reg.vs && DE_OUT == cur_reg.de;
  endproperty
  a_syncs: assert property (p_syncs) else $error("sync pins disagree with pixel"); // R7

  property p_full;
    fmt != FMT_HALF && load |=> VIDEO_OUT_BUS == full_word(cur_reg) ##1 $stable(VIDEO_OUT_BUS);
  endproperty
  a_full: assert property (p_full) else $error("full-width word wrong"); // R8

  property p_half_clk;
    fmt == FMT_HALF_CLK && $stable(fmt) && load |=>
      PIXEL_CLK_OUT != $past(PIXEL_CLK_OUT) ##1 $stable(PIXEL_CLK_OUT);
  endproperty
  a_half_clk: assert property (p_half_clk) else $error("half-rate clock wrong"); // R9

  c_half12: cover property (fmt == FMT_HALF && wid == BW_12 && load && cur_next.de);
  c_half_clk: cover property (fmt == FMT_HALF_CLK && load ##2 load);
  c_underrun: cover property (load && !head_valid ##2 load && head_valid);

endmodule : dual_edge_pixel_output

//--- pixel_sink_model.sv
// Receiver model that latches the output bus on both pin clock edges
`timescale 1ns/100ps

module pixel_sink_model (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  // Video pins
  input  wire logic [35:0] VIDEO_OUT_BUS,
  input  wire logic        PIXEL_CLK_OUT,
  input  wire logic        DE_OUT,
  // Captured words
  output logic [35:0]      rise_word,
  output logic [35:0]      fall_word,
  output int               n_rise
);
  logic clk_prev;

  // Pin edges seen in the MCLK domain; blank pixels are not kept
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      clk_prev  <= 1'b0;
      rise_word <= 36'h0_0000_0000;
      fall_word <= 36'h0_0000_0000;
      n_rise    <= 0;
    end else begin
      clk_prev <= PIXEL_CLK_OUT;
      if (DE_OUT && PIXEL_CLK_OUT && !clk_prev) begin
        rise_word <= VIDEO_OUT_BUS;
        n_rise    <= n_rise + 1;
      end
      if (DE_OUT && !PIXEL_CLK_OUT && clk_prev) begin
        fall_word <= VIDEO_OUT_BUS;
      end
    end
  end
endmodule : pixel_sink_model

//--- dual_edge_pixel_output_tb_top.sv
// Self-checking bench for the dual-edge pixel output
`timescale 1ns/100ps

module dual_edge_pixel_output_tb_top;
  import pixel_out_pkg::*;
  logic        MCLK;
  logic        RESET_N;
  logic [1:0]  OUT_FORMAT;
  logic [1:0]  BUS_WIDTH;
  logic        PIX_VALID;
  logic        PIX_READY;
  pixel_t      PIX_DATA;
  logic [35:0] VIDEO_OUT_BUS;
  logic        PIXEL_CLK_OUT;
  logic        HSYNC_OUT;
  logic        VSYNC_OUT;
  logic        DE_OUT;
  logic [35:0] rise_word;
  logic [35:0] fall_word;
  int          n_rise;
  int          bad_count;
  int          n_checks;

  dual_edge_pixel_output u_dual_edge_pixel_output (
    .MCLK(MCLK), .RESET_N(RESET_N), .OUT_FORMAT(OUT_FORMAT), .BUS_WIDTH(BUS_WIDTH),
    .PIX_VALID(PIX_VALID), .PIX_READY(PIX_READY), .PIX_DATA(PIX_DATA),
    .VIDEO_OUT_BUS(VIDEO_OUT_BUS), .PIXEL_CLK_OUT(PIXEL_CLK_OUT),
    .HSYNC_OUT(HSYNC_OUT), .VSYNC_OUT(VSYNC_OUT), .DE_OUT(DE_OUT));

  pixel_sink_model u_pixel_sink_model (
    .MCLK(MCLK), .RESET_N(RESET_N), .VIDEO_OUT_BUS(VIDEO_OUT_BUS),
    .PIXEL_CLK_OUT(PIXEL_CLK_OUT), .DE_OUT(DE_OUT), .rise_word(rise_word),
    .fall_word(fall_word), .n_rise(n_rise));

  // 10 MHz master clock
  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk(string name, logic [35:0] e, logic [35:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  function automatic pixel_t px(logic [3:0] k);
    return '{cr_r: 12'hA50 ^ k, y_g: 12'h3E0 ^ {k, k}, cb_b: 12'hC10 + k,
             hs: k[0], vs: k[1], de: 1'b1};
  endfunction : px

  // Narrow widths keep component MSBs; h low green bits ride with blue
  function automatic logic [35:0] exp_half(pixel_t p, logic [1:0] w, bit s);
    int n;
    int h;
    logic [35:0] b;
    logic [35:0] g;
    logic [35:0] r;
    n = (w == 2'h0) ? 12 : (w == 2'h1) ? 10 : 8;
    h = n / 2;
    b = 36'(p.cb_b >> (12 - n));
    g = 36'(p.y_g >> (12 - n));
    r = 36'(p.cr_r >> (12 - n));
    if (!s) return (b | ((g & ((36'h1 << h) - 1)) << n)) << ((12 - n) * 3 / 2);
    return ((g >> h) | (r << h)) << ((12 - n) * 3 / 2);
  endfunction : exp_half

  task automatic rst(logic [1:0] f, logic [1:0] w);
    @(posedge MCLK);
    RESET_N    <= 1'b0;
    OUT_FORMAT <= f;
    BUS_WIDTH  <= w;
    PIX_VALID  <= 1'b0;
    repeat (12) @(posedge MCLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge MCLK);
  endtask : rst

  // Hold the request until it is taken
  task automatic send(pixel_t p);
    @(posedge MCLK);
    PIX_VALID <= 1'b1;
    PIX_DATA  <= p;
    for (int i = 0; i <= 30; i++) begin
      @(posedge MCLK);
      if (PIX_READY === 1'b1) break;
      if (i == 30) begin
        bad_count++;
        test_done();
      end
    end
    PIX_VALID <= 1'b0;
  endtask : send

  task automatic wait_de;
    for (int i = 0; i <= 20; i++) begin
      @(negedge MCLK);
      if (DE_OUT === 1'b1) break;
      if (i == 20) begin
        bad_count++;
        test_done();
      end
    end
  endtask : wait_de

  // Half-width: pin clock at pixel rate, halves on its two edges
  task automatic t_half(logic [1:0] w);
    pixel_t p;
    p = px({2'b01, w});
    rst(FMT_HALF, w);
    send(p);
    wait_de();
    chk("clk_hi", 36'h1, 36'(PIXEL_CLK_OUT));
    chk("syncs", 36'({p.hs, p.vs}), 36'({HSYNC_OUT, VSYNC_OUT}));
    @(negedge MCLK);
    chk("clk_lo", 36'h0, 36'(PIXEL_CLK_OUT));
    chk("de", 36'h1, 36'(DE_OUT));
    repeat (3) @(negedge MCLK);
    chk("first", exp_half(p, w, 1'b0), rise_word);
    chk("second", exp_half(p, w, 1'b1), fall_word);
    chk("de_end", 36'h0, 36'(DE_OUT));
    // Literal 18-bit layout, independent of the shift model above
    if (w == 2'h0) chk("map18a", {18'h0_0000, p.y_g[5:0], p.cb_b}, rise_word);
    if (w == 2'h0) chk("map18b", {18'h0_0000, p.cr_r, p.y_g[11:6]}, fall_word);
  endtask : t_half

  // Full layout in both the full and the half-rate-clock formats
  task automatic t_wide(out_fmt_t f);
    logic   c;
    pixel_t a;
    pixel_t b;
    a = px(4'h1);
    b = px(4'h2);
    rst(f, BW_15);
    send(a);
    send(b);
    wait_de();
    c = PIXEL_CLK_OUT;
    chk("full0", {a.cr_r, a.y_g, a.cb_b}, VIDEO_OUT_BUS);
    @(negedge MCLK);
    chk("clk_a", (f == FMT_FULL) ? 36'h0 : 36'(c), 36'(PIXEL_CLK_OUT));
    chk("hold", {a.cr_r, a.y_g, a.cb_b}, VIDEO_OUT_BUS);
    @(negedge MCLK);
    chk("clk_b", 36'(f == FMT_FULL || !c), 36'(PIXEL_CLK_OUT));
    chk("full1", {b.cr_r, b.y_g, b.cb_b}, VIDEO_OUT_BUS);
  endtask : t_wide

  // Constant valid fills the FIFO; refused words must not appear
  task automatic t_fill;
    int acc;
    bit seen_full;
    acc = 0;
    seen_full = 1'b0;
    rst(FMT_HALF, BW_18);
    @(posedge MCLK);
    PIX_VALID <= 1'b1;
    PIX_DATA  <= px(4'h3);
    for (int i = 0; i < 40; i++) begin
      @(posedge MCLK);
      if (PIX_READY === 1'b1) acc++;
      else seen_full = 1'b1;
    end
    PIX_VALID <= 1'b0;
    repeat (40) @(negedge MCLK);
    chk("full_seen", 36'h1, 36'(seen_full));
    chk("count", 36'(acc), 36'(n_rise));
  endtask : t_fill

  initial begin
    bad_count  = 0;
    n_checks   = 0;
    RESET_N    = 1'b0;
    OUT_FORMAT = 2'h0;
    BUS_WIDTH  = 2'h0;
    PIX_VALID  = 1'b0;
    PIX_DATA   = '0;
    for (int w = 0; w < 3; w++) t_half(2'(w));
    t_wide(FMT_FULL);
    t_wide(FMT_HALF_CLK);
    t_fill();
    test_done();
  end
endmodule : dual_edge_pixel_output_tb_top
